/* File: logic/bsbmu_unit.sv */
// Byte shift, rotate and single-bit manipulation datapath.
`timescale 1ns/10ps
`include "bsbmu_params.svh"
// Notes on behaviour
// - Arithmetic shifts move a byte register one place and write it back.
// - Logical shifts move one place, fill the vacated bit with zero, write back.
// - Plain rotates move the bit leaving one end into the other end.
// - Carry rotates treat register plus carry as a nine-bit ring.
// - Set, clear, invert, test take bit number from immediate or register low bits.
// - Bit set forces the chosen bit to one, others unchanged.
// - Bit clear forces the chosen bit to zero, others unchanged.
// - Bit invert complements only the chosen bit and writes the byte back.
// - Bit test loads zero flag with inverse of chosen bit, operand untouched.
// - Carry becomes carry AND bit, or carry AND inverted bit.
// - Carry becomes carry OR bit, or carry OR inverted bit.
// - Carry becomes carry XOR bit, or carry XOR inverted bit.
// - Bit load copies the bit, or its inverse, into carry.
// - Bit store writes carry, or inverted carry, into the chosen bit.
// - Inverted carry operations always take the bit number from the immediate.

module bsbmu_unit
  import bsbmu_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire bsbmu_req_t                req,
  output logic                           req_ready,
  output logic                           mem_rd,
  input  wire logic                      mem_rd_ack,
  input  wire logic [`BSBMU_DATA_W-1:0]  mem_rd_data,
  output logic                           mem_wr,
  input  wire logic                      mem_wr_ack,
  output logic [`BSBMU_DATA_W-1:0]       mem_wr_data,
  output bsbmu_resp_t                    resp
);

  // ===================================================================
  // Helper functions.

  // True for the five inverted-operand carry operations.
  function automatic logic is_inv_op(input bsbmu_op_t op);
    is_inv_op = (op == OP_CARRY_AND_INV_BIT) || (op == OP_CARRY_OR_INV_BIT) ||
                (op == OP_CARRY_XOR_INV_BIT) || (op == OP_INV_BIT_TO_CARRY) ||
                (op == OP_INV_CARRY_TO_BIT);
  endfunction

  // Bit number select; inverted forms never look at the register.
  function automatic logic [`BSBMU_BITNO_W-1:0] bit_no(input bsbmu_req_t r);
    if (r.bit_from_reg && !is_inv_op(r.op)) begin
      bit_no = r.bit_reg[`BSBMU_BITNO_W-1:0];
    end else begin
      bit_no = r.imm_bit;
    end
  endfunction

  // One-hot mask of the selected bit.
  function automatic logic [`BSBMU_DATA_W-1:0] bit_mask(input logic [`BSBMU_BITNO_W-1:0] b);
    bit_mask = `BSBMU_DATA_W'(1) << b;
  endfunction

  // Execute one operation on a byte with the incoming flags.
  function automatic bsbmu_exec_t exec(input bsbmu_op_t op,
                                       input logic [`BSBMU_DATA_W-1:0] s,
                                       input logic [`BSBMU_BITNO_W-1:0] b,
                                       input bsbmu_flags_t f);
    logic [`BSBMU_DATA_W-1:0] m;
    logic                     sel;
    logic                     shift;
    m           = bit_mask(b);
    sel         = s[b];
    shift       = 1'b0;
    exec.data   = s;
    exec.writes = 1'b0;
    exec.flags  = f;
    case (op)
      OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
        exec.data    = {s[`BSBMU_MSB-1:0], 1'b0};
        exec.flags.c = s[`BSBMU_MSB];
        shift        = 1'b1;
      end
      OP_ARITH_SHIFT_RIGHT: begin
        exec.data    = {s[`BSBMU_MSB], s[`BSBMU_MSB:1]};
        exec.flags.c = s[0];
        shift        = 1'b1;
      end
      OP_LOGIC_SHIFT_RIGHT: begin
        exec.data    = {1'b0, s[`BSBMU_MSB:1]};
        exec.flags.c = s[0];
        shift        = 1'b1;
      end
      OP_ROTATE_LEFT: begin
        exec.data    = {s[`BSBMU_MSB-1:0], s[`BSBMU_MSB]};
        exec.flags.c = s[`BSBMU_MSB];
        shift        = 1'b1;
      end
      OP_ROTATE_RIGHT: begin
        exec.data    = {s[0], s[`BSBMU_MSB:1]};
        exec.flags.c = s[0];
        shift        = 1'b1;
      end
      OP_ROTATE_LEFT_VIA_CARRY: begin
        exec.data    = {s[`BSBMU_MSB-1:0], f.c};
        exec.flags.c = s[`BSBMU_MSB];
        shift        = 1'b1;
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        exec.data    = {f.c, s[`BSBMU_MSB:1]};
        exec.flags.c = s[0];
        shift        = 1'b1;
      end
      OP_BIT_SET: begin
        exec.data   = s | m;
        exec.writes = 1'b1;
      end
      OP_BIT_CLEAR: begin
        exec.data   = s & ~m;
        exec.writes = 1'b1;
      end
      OP_BIT_INVERT: begin
        exec.data   = s ^ m;
        exec.writes = 1'b1;
      end
      OP_BIT_TEST:          exec.flags.z = ~sel;
      OP_CARRY_AND_BIT:     exec.flags.c = f.c & sel;
      OP_CARRY_AND_INV_BIT: exec.flags.c = f.c & ~sel;
      OP_CARRY_OR_BIT:      exec.flags.c = f.c | sel;
      OP_CARRY_OR_INV_BIT:  exec.flags.c = f.c | ~sel;
      OP_CARRY_XOR_BIT:     exec.flags.c = f.c ^ sel;
      OP_CARRY_XOR_INV_BIT: exec.flags.c = f.c ^ ~sel;
      OP_BIT_TO_CARRY:      exec.flags.c = sel;
      OP_INV_BIT_TO_CARRY:  exec.flags.c = ~sel;
      OP_CARRY_TO_BIT, OP_INV_CARRY_TO_BIT: begin
        exec.data   = ((op == OP_CARRY_TO_BIT) ? f.c : ~f.c) ? (s | m) : (s & ~m);
        exec.writes = 1'b1;
      end
      default: exec.data = s;
    endcase
    // Every shift and rotate writes back and refreshes zero and negative.
    if (shift) begin
      exec.writes  = 1'b1;
      exec.flags.z = (exec.data == `BSBMU_DATA_W'(0));
      exec.flags.n = exec.data[`BSBMU_MSB];
    end
  endfunction

  // ===================================================================
  // State and working signals.
  bsbmu_state_t state_q;
  bsbmu_req_t   held_q;
  bsbmu_resp_t  resp_q;
  bsbmu_exec_t  ex;
  logic [`BSBMU_DATA_W-1:0] wdata_q;
  logic         take;

  assign req_ready = (state_q == ST_IDLE);
  assign take      = req.valid && req_ready;
  assign mem_rd    = (state_q == ST_READ);
  assign mem_wr    = (state_q == ST_WRITE);
  assign mem_wr_data = wdata_q;
  assign resp      = resp_q;

  // Register operands come straight in; memory bytes come from the read.
  always_comb begin
    if (state_q == ST_IDLE) begin
      ex = exec(req.op, req.operand, bit_no(req), req.flags);
    end else begin
      ex = exec(held_q.op, mem_rd_data, bit_no(held_q), held_q.flags);
    end
  end

  // ===================================================================
  // Sequencer: memory operands take a read and, if modified, a write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && req.to_mem) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_rd_ack) begin
            state_q <= ex.writes ? ST_WRITE : ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (mem_wr_ack) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Hold the request for the whole memory sequence.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_q <= '0;
    end else if (take) begin
      held_q <= req;
    end
  end

  // The whole modified byte goes back, never a single bit.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdata_q <= `BSBMU_RST_DATA;
    end else if (state_q == ST_READ && mem_rd_ack) begin
      wdata_q <= ex.data;
    end
  end

  // ===================================================================
  // Response register; valid pulses once per operation.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp_q <= '0;
    end else begin
      resp_q.valid <= `BSBMU_RST_BIT;
      if (take && !req.to_mem) begin
        resp_q <= '{valid: 1'b1, data: ex.data, wr_reg: ex.writes, flags: ex.flags};
      end else if (state_q == ST_READ && mem_rd_ack) begin
        // Read-only memory ops finish here; flags are final either way.
        resp_q.valid <= !ex.writes;
        resp_q.data  <= ex.data;
        resp_q.wr_reg <= 1'b0;
        resp_q.flags <= ex.flags;
      end else if (state_q == ST_WRITE && mem_wr_ack) begin
        resp_q.valid <= 1'b1;
      end
    end
  end

  // ===================================================================
  // Assertions on the register path and the memory sequence.
  logic acc_reg;
  assign acc_reg = take && !req.to_mem;

  property p_shift_left;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_LOGIC_SHIFT_LEFT |=>
      resp_q.valid && resp_q.data == {$past(req.operand[`BSBMU_MSB-1:0]), 1'b0} &&
      resp_q.flags.c == $past(req.operand[`BSBMU_MSB]);
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("left shift wrong");

  property p_asr_sign;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_ARITH_SHIFT_RIGHT |=>
      resp_q.data[`BSBMU_MSB] == $past(req.operand[`BSBMU_MSB]) &&
      resp_q.flags.n == $past(req.operand[`BSBMU_MSB]);
  endproperty
  a_asr_sign: assert property (p_asr_sign) else $error("sign not kept");

  property p_rot_carry;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_ROTATE_RIGHT_VIA_CARRY |=>
      resp_q.data[7] == $past(req.flags.c) && resp_q.flags.c == $past(req.operand[0]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("carry ring broken");

  property p_set_flags;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_BIT_SET |=>
      resp_q.flags == $past(req.flags) && resp_q.data[$past(bit_no(req))];
  endproperty
  a_set_flags: assert property (p_set_flags) else $error("bit set wrong");

  property p_test_zero;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_BIT_TEST |=>
      resp_q.flags.z != $past(req.operand[bit_no(req)]) && !resp_q.wr_reg;
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("bit test wrong");

  property p_inv_imm;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_INV_BIT_TO_CARRY |=>
      resp_q.flags.c == !$past(req.operand[req.imm_bit]);
  endproperty
  a_inv_imm: assert property (p_inv_imm) else $error("inverted op used register");

  property p_store_carry;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_CARRY_TO_BIT |=>
      resp_q.data[$past(bit_no(req))] == $past(req.flags.c) && resp_q.wr_reg;
  endproperty
  a_store_carry: assert property (p_store_carry) else $error("bit store wrong");

  property p_mem_rmw;
    @(posedge core_clk) disable iff (rst)
    state_q == ST_READ && mem_rd_ack && held_q.op == OP_BIT_CLEAR |=>
      mem_wr && $countones(mem_wr_data ^ $past(mem_rd_data)) <= 1 &&
      !mem_wr_data[$past(bit_no(held_q))];
  endproperty
  a_mem_rmw: assert property (p_mem_rmw) else $error("memory byte not rewritten");

  property p_and_flags;
    @(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_CARRY_AND_BIT |=>
      resp_q.flags.z == $past(req.flags.z) && resp_q.flags.n == $past(req.flags.n) &&
      resp_q.flags.c == ($past(req.flags.c) & $past(req.operand[bit_no(req)]));
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("carry and wrong");

  c_mem_write: cover property (@(posedge core_clk) disable iff (rst)
    mem_wr && mem_wr_ack);
  c_mem_read_only: cover property (@(posedge core_clk) disable iff (rst)
    state_q == ST_READ && mem_rd_ack && !ex.writes);
  c_reg_rotate: cover property (@(posedge core_clk) disable iff (rst)
    acc_reg && req.op == OP_ROTATE_LEFT_VIA_CARRY);
  c_reg_bit_from_reg: cover property (@(posedge core_clk) disable iff (rst)
    acc_reg && req.bit_from_reg && req.op == OP_BIT_INVERT);

endmodule

/* File: logic/bsbmu_params.svh */
// Constants for the byte shift and bit manipulation unit.
`ifndef BSBMU_PARAMS_SVH
`define BSBMU_PARAMS_SVH

// =====================================================================
// Widths
`define BSBMU_DATA_W    8
`define BSBMU_BITNO_W   3
`define BSBMU_OP_W      5
`define BSBMU_MSB       7

// =====================================================================
// Reset values
`define BSBMU_RST_DATA  8'h00
`define BSBMU_RST_BIT   1'b0

`endif

/* File: logic/bsbmu_pkg.sv */
// Types shared by the byte shift and bit manipulation unit.
`include "bsbmu_params.svh"

package bsbmu_pkg;

  // ===================================================================
  // Operation codes.
  typedef enum logic [`BSBMU_OP_W-1:0] {
    OP_ARITH_SHIFT_LEFT       = 5'h00,
    OP_ARITH_SHIFT_RIGHT      = 5'h01,
    OP_LOGIC_SHIFT_LEFT       = 5'h02,
    OP_LOGIC_SHIFT_RIGHT      = 5'h03,
    OP_ROTATE_LEFT            = 5'h04,
    OP_ROTATE_RIGHT           = 5'h05,
    OP_ROTATE_LEFT_VIA_CARRY  = 5'h06,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h07,
    OP_BIT_SET                = 5'h08,
    OP_BIT_CLEAR              = 5'h09,
    OP_BIT_INVERT             = 5'h0A,
    OP_BIT_TEST               = 5'h0B,
    OP_CARRY_AND_BIT          = 5'h0C,
    OP_CARRY_AND_INV_BIT      = 5'h0D,
    OP_CARRY_OR_BIT           = 5'h0E,
    OP_CARRY_OR_INV_BIT       = 5'h0F,
    OP_CARRY_XOR_BIT          = 5'h10,
    OP_CARRY_XOR_INV_BIT      = 5'h11,
    OP_BIT_TO_CARRY           = 5'h12,
    OP_INV_BIT_TO_CARRY       = 5'h13,
    OP_CARRY_TO_BIT           = 5'h14,
    OP_INV_CARRY_TO_BIT       = 5'h15
  } bsbmu_op_t;

  // ===================================================================
  // Sequencer states, Gray coded along idle, read, write.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11
  } bsbmu_state_t;

  // ===================================================================
  // Condition flags carried in and out.
  typedef struct packed {
    logic c;
    logic z;
    logic n;
  } bsbmu_flags_t;

  // One decoded operation from the instruction sequencer.
  typedef struct packed {
    logic                       valid;
    bsbmu_op_t                  op;
    logic [`BSBMU_DATA_W-1:0]   operand;
    logic [`BSBMU_BITNO_W-1:0]  imm_bit;
    logic [`BSBMU_DATA_W-1:0]   bit_reg;
    logic                       bit_from_reg;
    logic                       to_mem;
    bsbmu_flags_t               flags;
  } bsbmu_req_t;

  // Result of one operation.
  typedef struct packed {
    logic                       valid;
    logic [`BSBMU_DATA_W-1:0]   data;
    logic                       wr_reg;
    bsbmu_flags_t               flags;
  } bsbmu_resp_t;

  // Result of the combinational execute step.
  typedef struct packed {
    logic [`BSBMU_DATA_W-1:0]   data;
    logic                       writes;
    bsbmu_flags_t               flags;
  } bsbmu_exec_t;

endpackage

/* File: test/bsbmu_unit_tb_top.sv */
// Self-checking bench for the byte shift and bit manipulation unit.
`timescale 1ns/10ps

module bsbmu_unit_tb_top
  import bsbmu_pkg::*;
;
  // ===================================================================
  // Signals
  logic         core_clk;
  logic         rst;
  bsbmu_req_t   req;
  logic         req_ready;
  logic         mem_rd;
  logic         mem_rd_ack;
  logic [7:0]   mem_rd_data;
  logic         mem_wr;
  logic         mem_wr_ack;
  logic [7:0]   mem_wr_data;
  bsbmu_resp_t  resp;
  int           bad_count;
  int           num_checks;

  bsbmu_unit DUT (
    .core_clk    (core_clk),
    .rst         (rst),
    .req         (req),
    .req_ready   (req_ready),
    .mem_rd      (mem_rd),
    .mem_rd_ack  (mem_rd_ack),
    .mem_rd_data (mem_rd_data),
    .mem_wr      (mem_wr),
    .mem_wr_ack  (mem_wr_ack),
    .mem_wr_data (mem_wr_data),
    .resp        (resp)
  );

  // A 40 ns clock.
  always #20 core_clk = ~core_clk;

  // ===================================================================
  // Checking helpers
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // A wait that ran out is a mismatch and ends the run at once.
  task automatic hang_chk(input int i);
    if (i >= 20) begin
      $display("Error at %0t: got %h expected %h", $time, 8'h00, 8'h01);
      bad_count++;
      close_out();
    end
  endtask

  // Inverted carry ops take the bit number from the immediate only.
  function automatic logic is_inv(input bsbmu_op_t op);
    return op[0] && op >= OP_CARRY_AND_INV_BIT;
  endfunction

  // Reference result, built straight from the operation definitions.
  function automatic bsbmu_exec_t calc(input bsbmu_op_t op, input logic [7:0] d,
                                       input logic [2:0] b, input bsbmu_flags_t f);
    bsbmu_exec_t e;
    e.data  = d;
    e.flags = f;
    case (op)
      OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: {e.flags.c, e.data} = {d, 1'b0};
      OP_ARITH_SHIFT_RIGHT:      {e.data, e.flags.c} = {d[7], d};
      OP_LOGIC_SHIFT_RIGHT:      {e.data, e.flags.c} = {1'b0, d};
      OP_ROTATE_LEFT:            e.data = {d[6:0], d[7]};
      OP_ROTATE_RIGHT:           e.data = {d[0], d[7:1]};
      OP_ROTATE_LEFT_VIA_CARRY:  {e.flags.c, e.data} = {d, f.c};
      OP_ROTATE_RIGHT_VIA_CARRY: {e.data, e.flags.c} = {f.c, d};
      OP_BIT_SET:                e.data[b] = 1'b1;
      OP_BIT_CLEAR:              e.data[b] = 1'b0;
      OP_BIT_INVERT:             e.data[b] = ~d[b];
      OP_BIT_TEST:               e.flags.z = ~d[b];
      OP_CARRY_AND_BIT:          e.flags.c = f.c & d[b];
      OP_CARRY_AND_INV_BIT:      e.flags.c = f.c & ~d[b];
      OP_CARRY_OR_BIT:           e.flags.c = f.c | d[b];
      OP_CARRY_OR_INV_BIT:       e.flags.c = f.c | ~d[b];
      OP_CARRY_XOR_BIT:          e.flags.c = f.c ^ d[b];
      OP_CARRY_XOR_INV_BIT:      e.flags.c = f.c ^ ~d[b];
      OP_BIT_TO_CARRY:           e.flags.c = d[b];
      OP_INV_BIT_TO_CARRY:       e.flags.c = ~d[b];
      OP_CARRY_TO_BIT:           e.data[b] = f.c;
      OP_INV_CARRY_TO_BIT:       e.data[b] = ~f.c;
      default: ;
    endcase
    if (op <= OP_ROTATE_RIGHT_VIA_CARRY) begin
      e.flags.z = (e.data == 8'h00);
      e.flags.n = e.data[7];
    end
    e.writes = op <= OP_BIT_INVERT || op >= OP_CARRY_TO_BIT;
    return e;
  endfunction

  // ===================================================================
  // Register path: called at a falling edge, returns at the next one,
  // so consecutive calls issue one operation every cycle.
  task automatic issue(input bsbmu_op_t op, input logic [7:0] d, input logic [2:0] imm,
                       input logic [7:0] breg, input logic fr, input bsbmu_flags_t f);
    bsbmu_exec_t e;
    logic [2:0]  m;
    e = calc(op, d, (fr && !is_inv(op)) ? breg[2:0] : imm, f);
    // The carry after a plain rotate is left open, so it is not judged.
    m = (op == OP_ROTATE_LEFT || op == OP_ROTATE_RIGHT) ? 3'h3 : 3'h7;
    req = '{valid: 1'b1, op: op, operand: d, imm_bit: imm, bit_reg: breg,
            bit_from_reg: fr, to_mem: 1'b0, flags: f};
    @(posedge core_clk);
    @(negedge core_clk);
    chk(resp.valid, 1'b1);
    chk(resp.wr_reg, e.writes);
    if (e.writes || op == OP_BIT_TEST) chk(resp.data, e.data);
    chk(resp.flags & m, e.flags & m);
  endtask

  // ===================================================================
  // Scenarios
  task automatic test_reset();
    chk({req_ready, mem_rd, mem_wr, resp.valid}, 4'h8);
    // The whole response and the write byte come out of reset cleared.
    chk(resp, 16'h0000);
    chk(mem_wr_data, 8'h00);
    $display("test reset done");
  endtask

  // Every shift and rotate, back to back, on edge-case bytes.
  task automatic test_shifts();
    logic [7:0] vals [4] = '{8'h81, 8'h40, 8'h00, 8'hFE};
    for (int o = 0; o < 8; o++) begin
      for (int v = 0; v < 8; v++) begin
        issue(bsbmu_op_t'(o), vals[v % 4], 3'h0, 8'h00, 1'b0, {v[2], v[0], ~v[0]});
      end
    end
    req.valid = 1'b0;
    // Let an edge pass so the next scenario never re-drives valid in this step.
    @(negedge core_clk);
    $display("test shifts done");
  endtask

  // Every bit op, the inverted ones at even bit numbers only, the rest at every bit number; the unused source points elsewhere.
  task automatic test_bits();
    logic [2:0] b;
    for (int o = 8; o < 22; o++) begin
      for (int i = 0; i < 8; i++) begin
        b = i[2:0];
        issue(bsbmu_op_t'(o), 8'hA5 ^ o[7:0], i[0] ? ~b : b, i[0] ? {5'h15, b} : {5'h0A, ~b},
              i[0], {i[1], i[2], ~i[2]});
      end
    end
    req.valid = 1'b0;
    @(negedge core_clk);
    $display("test bits done");
  endtask

  // Memory byte: whole read, byte modified, whole write if the op writes, and a register
  // request held up meanwhile must be ignored.
  task automatic mem_op(input bsbmu_op_t op, input logic [7:0] d, input logic [2:0] b,
                        input bsbmu_flags_t f);
    bsbmu_exec_t e;
    int          i;
    e = calc(op, d, b, f);
    req = '{valid: 1'b1, op: op, operand: 8'h00, imm_bit: b, bit_reg: 8'h00,
            bit_from_reg: 1'b0, to_mem: 1'b1, flags: f};
    @(posedge core_clk);
    @(negedge core_clk);
    req.to_mem = 1'b0;
    req.op = OP_BIT_CLEAR;
    for (i = 0; i < 20 && mem_rd !== 1'b1; i++) @(negedge core_clk);
    hang_chk(i);
    chk(req_ready, 1'b0);
    mem_rd_ack = 1'b1;
    mem_rd_data = d;
    @(negedge core_clk);
    mem_rd_ack = 1'b0;
    mem_rd_data = ~d;
    if (e.writes) begin
      for (i = 0; i < 20 && mem_wr !== 1'b1; i++) @(negedge core_clk);
      hang_chk(i);
      chk(mem_wr_data, e.data);
      mem_wr_ack = 1'b1;
      @(negedge core_clk);
      mem_wr_ack = 1'b0;
    end
    chk({resp.valid, resp.wr_reg, mem_wr}, 3'h4);
    chk(resp.flags, e.flags);
    if (e.writes) chk(resp.data, e.data);
    req.valid = 1'b0;
    @(negedge core_clk);
    chk(resp.valid, 1'b0);
  endtask

  task automatic test_mem();
    mem_op(OP_BIT_SET, 8'h00, 3'h7, 3'h5);
    mem_op(OP_BIT_INVERT, 8'h5A, 3'h1, 3'h2);
    mem_op(OP_INV_CARRY_TO_BIT, 8'hFF, 3'h4, 3'h4);
    mem_op(OP_BIT_TEST, 8'h7F, 3'h7, 3'h1);
    mem_op(OP_CARRY_AND_BIT, 8'h01, 3'h0, 3'h7);
    mem_op(OP_BIT_CLEAR, 8'hFF, 3'h3, 3'h0);
    mem_op(OP_ARITH_SHIFT_RIGHT, 8'h96, 3'h0, 3'h2);
    $display("test mem done");
  endtask

  // ===================================================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    mem_rd_ack = 1'b0;
    mem_rd_data = 8'h00;
    mem_wr_ack = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    test_reset();
    test_shifts();
    test_bits();
    test_mem();
    close_out();
  end

endmodule
